//--- acc_pkg.sv
package acc_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int ACC_ADDR_W = 8;
    localparam int ACC_DATA_W = 8;
    localparam logic [7:0] ACC_OFS_CTRL_STATUS = 8'h00;
    localparam logic [7:0] ACC_OFS_CONV_CTRL_B = 8'h01;
    localparam logic [7:0] ACC_OFS_MUX_CONFIG = 8'h02;
    localparam logic [7:0] ACC_OFS_IRQ_STATUS = 8'h03;
    localparam logic [7:0] ACC_OFS_IRQ_MASK = 8'h04;

    // ---------------------------------------------------------------
    // Control and status field positions, plus the negative mux enable bit
    // ---------------------------------------------------------------
    localparam int ACC_BIT_OFF = 7;
    localparam int ACC_BIT_BANDGAP = 6;
    localparam int ACC_BIT_RESULT = 5;
    localparam int ACC_BIT_FLAG = 4;
    localparam int ACC_BIT_IRQ_EN = 3;
    localparam int ACC_BIT_LINK = 2;
    localparam int ACC_BIT_MODE_HI = 1;
    localparam int ACC_BIT_MODE_LO = 0;
    localparam int ACC_BIT_NEG_MUX = 6;

    // Mux configuration register fields.
    localparam int ACC_BIT_SEL_LO = 0;
    localparam int ACC_BIT_SEL_HI = 3;
    localparam int ACC_BIT_CONV_EN = 4;
    localparam int ACC_BIT_POWER_GATE = 5;

    // Interrupt status bits: mode event and any result change.
    localparam int ACC_IRQ_EVENT = 0;
    localparam int ACC_IRQ_CHANGE = 1;
    localparam int ACC_IRQ_W = 2;

    // ---------------------------------------------------------------
    // Event mode codes and reset values
    // ---------------------------------------------------------------
    localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
    localparam logic [1:0] ACC_MODE_RESERVED = 2'h1;
    localparam logic [1:0] ACC_MODE_FALLING = 2'h2;
    localparam logic [1:0] ACC_MODE_RISING = 2'h3;
    localparam logic [7:0] ACC_RST_MUX_CONFIG = 8'h20;
    localparam logic [ACC_IRQ_W-1:0] ACC_RST_IRQ = 2'h0;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic comparator_off;
        logic bandgap_select;
        logic compare_irq_enable;
        logic capture_link_enable;
        logic [1:0] event_mode;
    } acc_ctrl_t;

    typedef struct packed {
        logic negative_mux_enable;
        logic converter_enable;
        logic converter_power_gate;
        logic channel_select_high;
        logic [2:0] channel_select_low;
    } acc_mux_t;

    localparam acc_ctrl_t ACC_RST_CTRL = '0;

endpackage : acc_pkg

//--- acc_sync.sv
`timescale 1ns/1ps
module acc_sync
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    // Level to synchronise
    input wire logic async_in,
    output logic sync_out
);

    logic stage_one;

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            stage_one <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en_in) begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule : acc_sync

//--- acc_edge_detect.sv
`timescale 1ns/1ps
module acc_edge_detect
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    // Synchronised level and mode
    input wire logic level_in,
    input wire logic [1:0] mode_in,
    // Detected events
    output logic event_out,
    output logic change_out
);

    logic prev_level;

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            prev_level <= 1'b0;
        end else if (clk_en_in) begin
            prev_level <= level_in;
        end
    end

    wire rise = level_in & ~prev_level;
    wire fall = ~level_in & prev_level;

    assign change_out = rise | fall;

    assign event_out = (mode_in == ACC_MODE_TOGGLE) ? change_out :
                       (mode_in == ACC_MODE_FALLING) ? fall :
                       (mode_in == ACC_MODE_RISING) ? rise : 1'b0;

endmodule : acc_edge_detect

//--- acc_comparator_ctrl.sv
//
// Summary of operation
// - Result is high when selected positive input exceeds selected negative input.
// - Negative mux enabled and converter off: channel code picks channel 0 to 15.
// - Mux disabled or converter enabled: dedicated negative pin is used.
// - Converter power gate set makes the channel mux unavailable.
// - Writing comparator-off one switches comparator off; writable anytime.
// - Bandgap select picks bandgap reference, else the positive pin.
// - Result bit is synchronised, one to two cycles of latency.
// - Event flag sets when a transition matches the event mode.
// - Flag clears on vector taken or on writing one.
// - Request raised only with flag, enable and global enable all set.
// - Capture link routes result to the timer capture front end.
// - Mode: 00 toggle, 01 reserved, 10 falling, 11 rising.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module acc_comparator_ctrl
    import acc_pkg::*;
#(
    parameter int VOLT_W = 10,
    parameter int NUM_CHANNELS = 16,
    parameter logic [VOLT_W-1:0] BANDGAP_LEVEL = 10'h200
) (
    // Clock, reset and enable
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    // Register port
    input wire logic [ACC_ADDR_W-1:0] reg_addr_in,
    input wire logic [ACC_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [ACC_DATA_W-1:0] reg_rdata_out,
    // Sampled analog levels
    input wire logic [VOLT_W-1:0] positive_input_pin_in,
    input wire logic [VOLT_W-1:0] negative_input_pin_in,
    input wire logic [NUM_CHANNELS*VOLT_W-1:0] converter_channel_inputs_in,
    // Processor interrupt interface
    input wire logic global_irq_enable_in,
    input wire logic vector_taken_in,
    output logic compare_irq_out,
    output logic irq_out,
    // Timer capture front end
    output logic capture_trigger_out
);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    acc_ctrl_t ctrl;
    acc_mux_t mux;
    logic compare_event_flag;
    logic [ACC_IRQ_W-1:0] irq_status;
    logic [ACC_IRQ_W-1:0] irq_mask;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    wire hit_ctrl = reg_addr_in == ACC_OFS_CTRL_STATUS;
    wire hit_convb = reg_addr_in == ACC_OFS_CONV_CTRL_B;
    wire hit_muxc = reg_addr_in == ACC_OFS_MUX_CONFIG;
    wire hit_status = reg_addr_in == ACC_OFS_IRQ_STATUS;
    wire hit_mask = reg_addr_in == ACC_OFS_IRQ_MASK;
    wire wr_ctrl = reg_write_in & hit_ctrl;
    wire wr_convb = reg_write_in & hit_convb;
    wire wr_muxc = reg_write_in & hit_muxc;
    wire wr_status = reg_write_in & hit_status;
    wire wr_mask = reg_write_in & hit_mask;

    // ---------------------------------------------------------------
    // Input selection and comparison
    // ---------------------------------------------------------------
    wire [3:0] channel_code = {mux.channel_select_high, mux.channel_select_low};
    wire use_channel = mux.negative_mux_enable & ~mux.converter_enable &
                       ~mux.converter_power_gate;
    wire [VOLT_W-1:0] channel_level =
        converter_channel_inputs_in[channel_code*VOLT_W +: VOLT_W];
    wire [VOLT_W-1:0] negative_level = use_channel ? channel_level : negative_input_pin_in;
    wire [VOLT_W-1:0] positive_level = ctrl.bandgap_select ? BANDGAP_LEVEL :
                                       positive_input_pin_in;
    wire raw_compare = ~ctrl.comparator_off & (positive_level > negative_level);

    // ---------------------------------------------------------------
    // Synchronisation and event detection
    // ---------------------------------------------------------------
    logic compare_result;
    logic mode_event;
    logic result_change;

    acc_sync u_sync (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .clk_en_in(clk_en_in),
        .async_in(raw_compare),
        .sync_out(compare_result)
    );

    acc_edge_detect u_edge (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .clk_en_in(clk_en_in),
        .level_in(compare_result),
        .mode_in(ctrl.event_mode),
        .event_out(mode_event),
        .change_out(result_change)
    );

    // ---------------------------------------------------------------
    // Next values
    // ---------------------------------------------------------------
    wire flag_clear = (wr_ctrl & reg_wdata_in[ACC_BIT_FLAG]) | vector_taken_in;
    // Clear on vector or write one; a same-cycle set wins.
    wire next_flag = mode_event | (compare_event_flag & ~flag_clear);

    wire [ACC_IRQ_W-1:0] irq_events = {result_change, mode_event};
    wire [ACC_IRQ_W-1:0] irq_clear = wr_status ? reg_wdata_in[ACC_IRQ_W-1:0] : ACC_RST_IRQ;
    // Status bits are sticky; a new event beats a write-one clear.
    wire [ACC_IRQ_W-1:0] next_irq_status = irq_events | (irq_status & ~irq_clear);

    // Request needs flag and both enables.
    wire next_compare_irq = next_flag & ctrl.compare_irq_enable & global_irq_enable_in &
                            ~(wr_ctrl & ~reg_wdata_in[ACC_BIT_IRQ_EN]);
    wire next_irq = |(next_irq_status & irq_mask);
    wire next_capture = ctrl.capture_link_enable & compare_result;

    wire [7:0] ctrl_read = {ctrl.comparator_off, ctrl.bandgap_select, compare_result,
                            compare_event_flag, ctrl.compare_irq_enable,
                            ctrl.capture_link_enable, ctrl.event_mode};
    wire [7:0] convb_read = {1'b0, mux.negative_mux_enable, 6'h00};
    wire [7:0] muxc_read = {2'h0, mux.converter_power_gate, mux.converter_enable,
                            mux.channel_select_high, mux.channel_select_low};
    wire [7:0] next_rdata = hit_ctrl ? ctrl_read :
                            hit_convb ? convb_read :
                            hit_muxc ? muxc_read :
                            hit_status ? {6'h00, irq_status} :
                            hit_mask ? {6'h00, irq_mask} : 8'h00;

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ctrl <= ACC_RST_CTRL;
        end else if (clk_en_in && wr_ctrl) begin
            ctrl.comparator_off <= reg_wdata_in[ACC_BIT_OFF];
            ctrl.bandgap_select <= reg_wdata_in[ACC_BIT_BANDGAP];
            ctrl.compare_irq_enable <= reg_wdata_in[ACC_BIT_IRQ_EN];
            ctrl.capture_link_enable <= reg_wdata_in[ACC_BIT_LINK];
            ctrl.event_mode <= reg_wdata_in[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO];
        end
    end

    // The power gate comes out of reset set, so the mux is unusable until cleared.
    // Both mux registers live in one struct, so one process owns all of its fields.
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            mux.negative_mux_enable <= 1'b0;
            mux.converter_power_gate <= ACC_RST_MUX_CONFIG[ACC_BIT_POWER_GATE];
            mux.converter_enable <= ACC_RST_MUX_CONFIG[ACC_BIT_CONV_EN];
            mux.channel_select_high <= ACC_RST_MUX_CONFIG[ACC_BIT_SEL_HI];
            mux.channel_select_low <= ACC_RST_MUX_CONFIG[ACC_BIT_SEL_LO +: 3];
        end else if (clk_en_in) begin
            if (wr_convb) begin
                mux.negative_mux_enable <= reg_wdata_in[ACC_BIT_NEG_MUX];
            end
            if (wr_muxc) begin
                mux.converter_power_gate <= reg_wdata_in[ACC_BIT_POWER_GATE];
                mux.converter_enable <= reg_wdata_in[ACC_BIT_CONV_EN];
                mux.channel_select_high <= reg_wdata_in[ACC_BIT_SEL_HI];
                mux.channel_select_low <= reg_wdata_in[ACC_BIT_SEL_LO +: 3];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            irq_mask <= ACC_RST_IRQ;
        end else if (clk_en_in && wr_mask) begin
            irq_mask <= reg_wdata_in[ACC_IRQ_W-1:0];
        end
    end

    // ---------------------------------------------------------------
    // Flags, outputs and read data
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            compare_event_flag <= 1'b0;
            irq_status <= ACC_RST_IRQ;
            compare_irq_out <= 1'b0;
            irq_out <= 1'b0;
            capture_trigger_out <= 1'b0;
            reg_rdata_out <= 8'h00;
        end else if (clk_en_in) begin
            compare_event_flag <= next_flag;
            irq_status <= next_irq_status;
            compare_irq_out <= next_compare_irq;
            irq_out <= next_irq;
            capture_trigger_out <= next_capture;
            reg_rdata_out <= reg_read_in ? next_rdata : 8'h00;
        end
    end

endmodule : acc_comparator_ctrl

//--- acc_comparator_ctrl_asserts.sv
`timescale 1ns/1ps
module acc_comparator_ctrl_asserts
    import acc_pkg::*;
#(
    parameter int VOLT_W = 10,
    parameter int NUM_CHANNELS = 16
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    // Register port
    input wire logic [ACC_ADDR_W-1:0] reg_addr_in,
    input wire logic [ACC_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [ACC_DATA_W-1:0] reg_rdata_out,
    // Analog levels
    input wire logic [VOLT_W-1:0] positive_input_pin_in,
    input wire logic [VOLT_W-1:0] negative_input_pin_in,
    input wire logic [NUM_CHANNELS*VOLT_W-1:0] converter_channel_inputs_in,
    // Interrupts and capture
    input wire logic global_irq_enable_in,
    input wire logic vector_taken_in,
    input wire logic compare_irq_out,
    input wire logic irq_out,
    input wire logic capture_trigger_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    // -----------------------------------------------------------
    // Six still cycles flush the synchroniser and the flag stages.
    // -----------------------------------------------------------
    sequence quiet_s;
        (clk_en_in && !reg_write_in && !vector_taken_in && $stable(global_irq_enable_in)
            && $stable(positive_input_pin_in) && $stable(negative_input_pin_in)
            && $stable(converter_channel_inputs_in))[*6];
    endsequence
    wire ctrl_wr = reg_write_in && reg_addr_in == ACC_OFS_CTRL_STATUS;

    chk_gie_gates_irq: assert property (
        compare_irq_out |-> $past(global_irq_enable_in)) else $error("irq without global enable");
    chk_gie_drop_irq: assert property (
        !global_irq_enable_in |=> !compare_irq_out) else $error("irq kept after global off");
    chk_vector_clears: assert property (
        quiet_s ##1 vector_taken_in |=> ##1 !compare_irq_out) else $error("vector left irq");
    chk_capture_quiet: assert property (
        quiet_s |-> $stable(capture_trigger_out)) else $error("capture moved while still");
    chk_irq_quiet: assert property (
        quiet_s |-> $stable(compare_irq_out)) else $error("irq moved while still");
    chk_status_quiet: assert property (
        quiet_s |-> $stable(irq_out)) else $error("status irq moved while still");
    chk_link_off: assert property (
        ctrl_wr && !reg_wdata_in[ACC_BIT_LINK] |=> ##1 !capture_trigger_out)
        else $error("capture without link");
    chk_enable_off: assert property (
        ctrl_wr && !reg_wdata_in[ACC_BIT_IRQ_EN] |=> ##1 !compare_irq_out)
        else $error("irq without enable");

    cover property (vector_taken_in && compare_irq_out);
    cover property ($rose(irq_out));
    cover property ($rose(capture_trigger_out));
endmodule : acc_comparator_ctrl_asserts

bind acc_comparator_ctrl acc_comparator_ctrl_asserts #(
    .VOLT_W(VOLT_W), .NUM_CHANNELS(NUM_CHANNELS)
) u_asserts (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .positive_input_pin_in(positive_input_pin_in), .negative_input_pin_in(negative_input_pin_in),
    .converter_channel_inputs_in(converter_channel_inputs_in),
    .global_irq_enable_in(global_irq_enable_in), .vector_taken_in(vector_taken_in),
    .compare_irq_out(compare_irq_out), .irq_out(irq_out),
    .capture_trigger_out(capture_trigger_out));

//--- acc_analog_src.sv
`timescale 1ns/1ps
module acc_analog_src
    import acc_pkg::*;
#(
    parameter int VOLT_W = 10,
    parameter int NUM_CHANNELS = 16,
    parameter int CH_STEP = 32
) (
    // Clock
    input wire logic ref_clk_in,
    // Requested pin levels
    input wire logic [VOLT_W-1:0] pos_level_in,
    input wire logic [VOLT_W-1:0] neg_level_in,
    // Levels seen by the comparator
    output logic [VOLT_W-1:0] positive_input_pin_out,
    output logic [VOLT_W-1:0] negative_input_pin_out,
    output logic [NUM_CHANNELS*VOLT_W-1:0] converter_channel_inputs_out
);
    // Each channel sits on its own ladder step, so a wrong channel pick shows up.
    for (genvar n = 0; n < NUM_CHANNELS; n++) begin : g_ch
        assign converter_channel_inputs_out[n*VOLT_W +: VOLT_W] = VOLT_W'(n * CH_STEP);
    end
    always_ff @(posedge ref_clk_in) begin
        positive_input_pin_out <= pos_level_in;
        negative_input_pin_out <= neg_level_in;
    end
endmodule : acc_analog_src

//--- analog_comparator_control_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
`define PORT(nm, e, g) begin @(negedge ref_clk_in); `CHK(nm, e, g) @(posedge ref_clk_in); end
module analog_comparator_control_tb
    import acc_pkg::*;
;
    localparam int STEP = 32;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic clk_en = 1'b1;
    logic gie = 1'b0;
    logic vec = 1'b0;
    logic [9:0] pos_lvl = 10'h000;
    logic [9:0] neg_lvl = 10'h000;
    logic [7:0] rdata;
    logic cmp_irq, irq, cap;
    logic [9:0] pos_pin, neg_pin;
    logic [159:0] chans;
    int fails = 0;
    int check_count = 0;
    always #20 ref_clk_in = ~ref_clk_in;

    acc_analog_src #(.CH_STEP(STEP)) src (.ref_clk_in(ref_clk_in), .pos_level_in(pos_lvl),
        .neg_level_in(neg_lvl), .positive_input_pin_out(pos_pin),
        .negative_input_pin_out(neg_pin), .converter_channel_inputs_out(chans));
    acc_comparator_ctrl dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(rdata), .positive_input_pin_in(pos_pin),
        .negative_input_pin_in(neg_pin), .converter_channel_inputs_in(chans),
        .global_irq_enable_in(gie), .vector_taken_in(vec), .compare_irq_out(cmp_irq),
        .irq_out(irq), .capture_trigger_out(cap));

    // -----------------------------------------------------------
    // Register access and stimulus tasks
    // -----------------------------------------------------------
    task automatic tick(input int n);
        reg_write_in <= 1'b0;
        repeat (n) @(posedge ref_clk_in);
    endtask : tick
    // The write strobe stays up so that a following write needs no gap; tick and rd lower it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge ref_clk_in);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        reg_write_in <= 1'b0;
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_read_in <= 1'b0;
        @(negedge ref_clk_in);
        `CHK($sformatf("reg %h", a), e, rdata & m)
        @(posedge ref_clk_in);
    endtask : rd
    task automatic cfg(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        wr(a, d);
        tick(3);
        rd(8'h00, 8'h20, e);
    endtask : cfg
    task automatic lv(input logic [9:0] p, input logic [9:0] n);
        pos_lvl <= p;
        neg_lvl <= n;
        tick(6);
    endtask : lv
    task automatic give_verdict();
        if (fails == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    initial begin
        tick(6);
        reset_n_in <= 1'b1;
        for (int a = 0; a < 6; a++) rd(8'(a), 8'hFF, (a == 2) ? 8'h20 : 8'h00);
        lv(10'd600, 10'd500);
        rd(8'h00, 8'h20, 8'h20);
        `PORT("capture unlinked", 1'b0, cap)
        wr(8'h00, 8'h40);
        lv(10'd100, 10'd500);
        rd(8'h00, 8'h20, 8'h20);
        lv(10'd100, 10'd520);
        rd(8'h00, 8'h20, 8'h00);
        wr(8'h00, 8'h04);
        pos_lvl <= 10'd600;
        tick(3);
        `PORT("capture early", 1'b0, cap)
        `PORT("capture", 1'b1, cap)
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h40);
        for (int k = 0; k < 16; k++) begin
            wr(8'h02, 8'(k));
            lv(10'(k * STEP + 16), 10'h3FF);
            rd(8'h00, 8'h20, 8'h20);
            lv(10'(k * STEP), 10'h3FF);
            rd(8'h00, 8'h20, 8'h00);
        end
        lv(10'(15 * STEP + 16), 10'h3FF);
        cfg(8'h02, 8'h1F, 8'h00);
        cfg(8'h02, 8'h2F, 8'h00);
        cfg(8'h02, 8'h0F, 8'h20);
        cfg(8'h01, 8'h00, 8'h00);
        for (int m = 0; m < 4; m++) begin
            lv(10'd100, 10'd200);
            wr(8'h00, 8'h10 | 8'(m));
            lv(10'd300, 10'd200);
            rd(8'h00, 8'h10, (m == 0 || m == 3) ? 8'h10 : 8'h00);
            wr(8'h00, 8'h10 | 8'(m));
            lv(10'd100, 10'd200);
            rd(8'h00, 8'h10, (m == 0 || m == 2) ? 8'h10 : 8'h00);
        end
        gie <= 1'b1;
        wr(8'h00, 8'h1B);
        wr(8'h04, 8'h01);
        wr(8'h03, 8'h03);
        lv(10'd300, 10'd200);
        `PORT("compare irq", 1'b1, cmp_irq)
        `PORT("status irq", 1'b1, irq)
        rd(8'h03, 8'hFF, 8'h03);
        gie <= 1'b0;
        tick(2);
        `PORT("irq gated", 1'b0, cmp_irq)
        gie <= 1'b1;
        tick(6);
        `PORT("irq again", 1'b1, cmp_irq)
        vec <= 1'b1;
        tick(1);
        vec <= 1'b0;
        tick(2);
        `PORT("irq after vector", 1'b0, cmp_irq)
        rd(8'h00, 8'h10, 8'h00);
        wr(8'h03, 8'h01);
        tick(1);
        `PORT("status cleared", 1'b0, irq)
        wr(8'h04, 8'h02);
        tick(1);
        `PORT("change unmasked", 1'b1, irq)
        wr(8'h03, 8'h02);
        tick(1);
        `PORT("status idle", 1'b0, irq)
        lv(10'd100, 10'd200);
        lv(10'd300, 10'd200);
        `PORT("irq rise", 1'b1, cmp_irq)
        wr(8'h00, 8'h03);
        tick(1);
        `PORT("irq enable off", 1'b0, cmp_irq)
        rd(8'h00, 8'h10, 8'h10);
        wr(8'h00, 8'h13);
        rd(8'h00, 8'h10, 8'h00);
        wr(8'h00, 8'h83);
        tick(3);
        rd(8'h00, 8'h20, 8'h00);
        wr(8'h00, 8'h03);
        tick(3);
        rd(8'h00, 8'h20, 8'h20);
        wr(8'h00, 8'h04);
        tick(3);
        clk_en <= 1'b0;
        lv(10'd100, 10'd200);
        `PORT("frozen capture", 1'b1, cap)
        clk_en <= 1'b1;
        tick(3);
        `PORT("capture thawed", 1'b0, cap)
        give_verdict();
    end

    initial begin
        #1000000;
        fails++;
        give_verdict();
    end
endmodule : analog_comparator_control_tb
